// ===== comparator_group.sv
`timescale 1ns/1ps
module comparator_group
	import supervisor_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic hold,
	input wire logic groupOn,
	input wire group_cfg_t cfgIn,
	input wire logic [NUM_CHANNELS-1:0] tripIn,
	output group_stat_t stat,
	output logic [NUM_CHANNELS-1:0] trips
);
	group_cfg_t cfg; // latched configuration
	group_cfg_t next_cfg;
	logic onPrev;
	logic next_onPrev;
	logic live; // latched by a real enable edge and still on
	logic next_live;
	logic [2:0] chan;
	logic [2:0] next_chan;
	logic [15:0] slotCnt;
	logic [15:0] next_slotCnt;
	logic bistCycle; // toggles each round in MODE_BIST_RR; bist on alternate rounds
	logic next_bistCycle;
	logic [NUM_CHANNELS-1:0] next_trips;
	logic single;
	logic [2:0] lowest;

	// lowest enabled channel, picked by priority
	always_comb begin
		lowest = 3'h0;
		for (int i = NUM_CHANNELS - 1; i >= 0; i--) begin
			if (cfg.chanEnables[i]) begin
				lowest = i[2:0];
			end
		end
	end

	assign single = (cfg.mode == MODE_SINGLE_A) ||
		(cfg.mode == MODE_SINGLE_B);

	// config latch, channel sequencing and trip capture
	always_comb begin
		next_onPrev = groupOn;
		next_live = live;
		next_cfg = cfg;
		next_chan = chan;
		next_slotCnt = slotCnt;
		next_bistCycle = bistCycle;
		next_trips = trips;
		// only a rising enable loads new settings
		if (groupOn && !onPrev) begin
			next_cfg = cfgIn;
			next_live = 1'b1;
			next_chan = 3'h0;
			next_slotCnt = 16'h0000;
			next_bistCycle = 1'b0;
			next_trips = '0;
		end else if (!groupOn || !live) begin
			// off, or parked until the enable is toggled again
			next_live = 1'b0;
			next_trips = '0;
		end else if (single) begin
			// parked on one channel, no cycling, no self-test
			next_chan = lowest;
			next_bistCycle = 1'b0;
			// masked while threshold is measured
			if (!cfg.thresholdMeas) begin
				next_trips[lowest] = tripIn[lowest];
			end
		end else begin
			if (slotCnt == 16'(SLOT_CYCLES - 1)) begin
				next_slotCnt = 16'h0000;
				if (chan == 3'(NUM_CHANNELS - 1)) begin
					next_chan = 3'h0;
					// default mode runs self-test every other round
					if (cfg.mode == MODE_BIST_RR) begin
						next_bistCycle = !bistCycle;
					end else begin
						next_bistCycle = 1'b0;
					end
				end else begin
					next_chan = chan + 3'h1;
				end
			end else begin
				next_slotCnt = slotCnt + 16'h0001;
			end
			if (cfg.chanEnables[chan]) begin
				next_trips[chan] = tripIn[chan];
			end
		end
		// reset holds everything but the enable level tracker at defaults
		if (hold) begin
			next_cfg = '0;
			next_chan = 3'h0;
			next_slotCnt = 16'h0000;
			next_bistCycle = 1'b0;
			next_trips = '0;
			// enable level still tracked, so no relatch without a toggle
			next_live = 1'b0;
		end
	end

	// registers only
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cfg <= '0;
			onPrev <= 1'b0;
			live <= 1'b0;
			chan <= 3'h0;
			slotCnt <= 16'h0000;
			bistCycle <= 1'b0;
			trips <= '0;
		end else begin
			cfg <= next_cfg;
			onPrev <= next_onPrev;
			live <= next_live;
			chan <= next_chan;
			slotCnt <= next_slotCnt;
			bistCycle <= next_bistCycle;
			trips <= next_trips;
		end
	end

	// status, combinational from registers and the enable input
	always_comb begin
		stat.running = groupOn && live;
		stat.singleMode = single;
		stat.bistActive = groupOn && live && !single && bistCycle;
		stat.outputsMasked = groupOn && live && single &&
			cfg.thresholdMeas;
		stat.channel = chan;
	end
endmodule

// ===== protector_supervisor.sv
`timescale 1ns/1ps
module protector_supervisor
	import supervisor_pkg::*;
#(
	parameter int WAKE_HOLD = WAKE_HOLD_CYCLES,
	parameter int SLOW_WD = SLOW_WD_CYCLES
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic isStackDevice,
	input wire logic tempComparatorsOn,
	input wire logic voltComparatorsOn,
	input wire group_cfg_t tempCfg,
	input wire group_cfg_t voltCfg,
	input wire logic [NUM_CHANNELS-1:0] tempTrip,
	input wire logic [NUM_CHANNELS-1:0] voltTrip,
	input wire logic dieOverTemp,
	input wire logic dieBelowRelease,
	input wire logic cellConvDone,
	input wire logic dieAboveWarn,
	input wire logic fastOscillator,
	input wire logic slowOscillator,
	input wire logic supplyValid,
	input wire logic referenceValid,
	input wire logic bandgapValid,
	input wire logic softReset,
	input wire logic wakeTone,
	input wire logic wakePinLow,
	input wire logic wakeCommand,
	input wire logic clearThermalShutdown,
	input wire logic clearThermalWarning,
	input wire logic clearOscillatorFault,
	input wire logic clearResetOccurred,
	input wire logic [3:0] faultMask,
	output group_stat_t tempStat,
	output group_stat_t voltStat,
	output logic [NUM_CHANNELS-1:0] tempFaults,
	output logic [NUM_CHANNELS-1:0] voltFaults,
	output logic inShutdown,
	output logic discardTraffic,
	output logic digitalReset,
	output logic thermalShutdownFlag,
	output logic thermalWarningFlag,
	output logic oscillatorFaultFlag,
	output logic resetOccurredFlag,
	output logic faultOutputLow
);
	// power state kept only as much as shutdown needs
	typedef enum logic [1:0] {RUN, SHUT, WAKING} pstate_t;
	pstate_t pstate, next_pstate;
	logic next_thermalShutdownFlag, next_thermalWarningFlag;
	logic next_oscillatorFaultFlag, next_resetOccurredFlag;
	logic [CNT_W-1:0] fastCnt, next_fastCnt; // time since fast edge
	logic [CNT_W-1:0] slowCnt, next_slowCnt; // time since slow edge
	logic [CNT_W-1:0] wakeCnt, next_wakeCnt; // wake pin low time
	logic fastPrev, next_fastPrev, slowPrev, next_slowPrev;
	logic wakePrev, next_wakePrev;
	logic supplyHold, next_supplyHold; // supply-caused reset latch
	logic pulseReset, next_pulseReset; // registered reset from events, held while a watchdog stays tripped
	logic fastToggle, slowToggle, supplyBad, wakeReleaseLong;
	logic fastTimeout, slowTimeout, holdLogic;

	assign fastToggle = fastOscillator != fastPrev;
	assign slowToggle = slowOscillator != slowPrev;
	assign supplyBad = !supplyValid || !referenceValid || !bandgapValid;
	assign fastTimeout = fastCnt >= CNT_W'(FAST_WD_CYCLES);
	assign slowTimeout = slowCnt >= CNT_W'(SLOW_WD);
	// long low then release on a base device
	assign wakeReleaseLong = !isStackDevice && wakePrev && !wakePinLow &&
		(wakeCnt >= CNT_W'(WAKE_HOLD));
	// digital reset: supply latch or a registered event reset
	assign digitalReset = supplyHold || pulseReset;
	assign holdLogic = digitalReset || (pstate == SHUT);
	assign inShutdown = pstate == SHUT;
	// pending port traffic is dropped while shut down or reset
	assign discardTraffic = holdLogic;

	comparator_group tempGroup (
		.clock(clock),
		.rstn(rstn),
		.hold(holdLogic),
		.groupOn(tempComparatorsOn),
		.cfgIn(tempCfg),
		.tripIn(tempTrip),
		.stat(tempStat),
		.trips(tempFaults)
	);

	comparator_group voltGroup (
		.clock(clock),
		.rstn(rstn),
		.hold(holdLogic),
		.groupOn(voltComparatorsOn),
		.cfgIn(voltCfg),
		.tripIn(voltTrip),
		.stat(voltStat),
		.trips(voltFaults)
	);

	// watchdogs, wake pin timer and reset sources
	always_comb begin
		next_fastPrev = fastOscillator;
		next_slowPrev = slowOscillator;
		next_wakePrev = wakePinLow;
		next_fastCnt = fastToggle ? '0 : fastCnt;
		next_slowCnt = slowToggle ? '0 : slowCnt;
		// saturate so a dead clock keeps the watchdog tripped
		if (!fastToggle && !fastTimeout) begin
			next_fastCnt = fastCnt + CNT_W'(1);
		end
		if (!slowToggle && !slowTimeout) begin
			next_slowCnt = slowCnt + CNT_W'(1);
		end
		if (!wakePinLow) begin
			next_wakeCnt = '0;
		end else if (wakeCnt != '1) begin
			next_wakeCnt = wakeCnt + CNT_W'(1);
		end else begin
			next_wakeCnt = wakeCnt;
		end
		// supply reset released only when all three recover
		next_supplyHold = supplyBad;
		next_pulseReset = fastTimeout || slowTimeout || softReset ||
			(isStackDevice && wakeTone) || wakeReleaseLong;
	end

	// power state and sticky flags
	always_comb begin
		next_pstate = pstate;
		next_thermalShutdownFlag = thermalShutdownFlag;
		next_thermalWarningFlag = thermalWarningFlag;
		next_oscillatorFaultFlag = oscillatorFaultFlag;
		next_resetOccurredFlag = resetOccurredFlag;
		case (pstate)
			RUN: begin
				if (dieOverTemp) begin
					next_pstate = SHUT;
				end
			end
			SHUT: begin
				// wakeup honoured only once the die has cooled
				if (wakeCommand && dieBelowRelease) begin
					next_pstate = WAKING;
				end
			end
			WAKING: begin
				// a trip while starting up shuts down at once
				if (dieOverTemp) begin
					next_pstate = SHUT;
				end else begin
					next_pstate = RUN;
				end
			end
			default: begin
				next_pstate = RUN;
			end
		endcase
		// clears first so a same-cycle set wins
		if (clearThermalShutdown) begin
			next_thermalShutdownFlag = 1'b0;
		end
		if (clearThermalWarning) begin
			next_thermalWarningFlag = 1'b0;
		end
		if (clearOscillatorFault) begin
			next_oscillatorFaultFlag = 1'b0;
		end
		if (clearResetOccurred) begin
			next_resetOccurredFlag = 1'b0;
		end
		if (dieOverTemp) begin
			next_thermalShutdownFlag = 1'b1;
		end
		if (pstate != SHUT && cellConvDone && dieAboveWarn) begin
			next_thermalWarningFlag = 1'b1;
		end
		// half period outside the window flags the slow clock
		if (slowToggle && (slowCnt < CNT_W'(SLOW_HALF_MIN) ||
			slowCnt > CNT_W'(SLOW_HALF_MAX))) begin
			next_oscillatorFaultFlag = 1'b1;
		end
		if (slowTimeout) begin
			next_oscillatorFaultFlag = 1'b1;
		end
		if (digitalReset || pstate == WAKING) begin
			next_resetOccurredFlag = 1'b1;
		end
		// a digital reset wipes warning but keeps thermal and reset flags
		if (digitalReset) begin
			next_thermalWarningFlag = 1'b0;
		end
	end

	// fault line: silent in shutdown, flags shown once awake
	always_comb begin
		faultOutputLow = !((pstate == RUN) && !digitalReset && (
			(thermalShutdownFlag && !faultMask[0]) ||
			(thermalWarningFlag && !faultMask[1]) ||
			(oscillatorFaultFlag && !faultMask[2]) ||
			((|tempFaults || |voltFaults) && !faultMask[3])));
	end

	// registers only
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pstate <= RUN;
			thermalShutdownFlag <= 1'b0;
			thermalWarningFlag <= 1'b0;
			oscillatorFaultFlag <= 1'b0;
			resetOccurredFlag <= 1'b1; // power-up counts as a reset
			fastCnt <= '0;
			slowCnt <= '0;
			wakeCnt <= '0;
			fastPrev <= 1'b0;
			slowPrev <= 1'b0;
			wakePrev <= 1'b0;
			supplyHold <= 1'b0;
			pulseReset <= 1'b0;
		end else begin
			pstate <= next_pstate;
			thermalShutdownFlag <= next_thermalShutdownFlag;
			thermalWarningFlag <= next_thermalWarningFlag;
			oscillatorFaultFlag <= next_oscillatorFaultFlag;
			resetOccurredFlag <= next_resetOccurredFlag;
			fastCnt <= next_fastCnt;
			slowCnt <= next_slowCnt;
			wakeCnt <= next_wakeCnt;
			fastPrev <= next_fastPrev;
			slowPrev <= next_slowPrev;
			wakePrev <= next_wakePrev;
			supplyHold <= next_supplyHold;
			pulseReset <= next_pulseReset;
		end
	end
endmodule

// ===== protector_supervisor_properties.sv
`timescale 1ns/1ps
module supervisor_checker
	import supervisor_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic dieOverTemp,
	input wire logic dieBelowRelease,
	input wire logic wakeCommand,
	input wire logic cellConvDone,
	input wire logic dieAboveWarn,
	input wire logic softReset,
	input wire logic supplyValid,
	input wire logic clearThermalShutdown,
	input wire logic clearResetOccurred,
	input wire group_stat_t tempStat,
	input wire group_stat_t voltStat,
	input wire logic inShutdown,
	input wire logic discardTraffic,
	input wire logic digitalReset,
	input wire logic thermalShutdownFlag,
	input wire logic thermalWarningFlag,
	input wire logic resetOccurredFlag,
	input wire logic faultOutputLow
);
	// one domain, so clock and reset are given once
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);
	// a wake that may be honoured: die cool, sensor quiet
	sequence s_wakeOk;
		inShutdown && wakeCommand && dieBelowRelease && !dieOverTemp;
	endsequence
	property p_tsdEnter;
		dieOverTemp |=> inShutdown && thermalShutdownFlag;
	endproperty
	a_tsdEnter: assert property (p_tsdEnter) else $error("no shutdown");
	property p_discard;
		inShutdown || digitalReset |-> discardTraffic;
	endproperty
	a_discard: assert property (p_discard) else $error("traffic kept");
	// an already quiet fault line must stay quiet on shutdown
	property p_quiet;
		$rose(inShutdown) && $past(faultOutputLow) |-> faultOutputLow;
	endproperty
	a_quiet: assert property (p_quiet) else $error("fault on shutdown");
	property p_tsdKeep;
		thermalShutdownFlag && !clearThermalShutdown |=> thermalShutdownFlag;
	endproperty
	a_tsdKeep: assert property (p_tsdKeep) else $error("flag lost");
	property p_stayDown;
		inShutdown && !(wakeCommand && dieBelowRelease) |=> inShutdown;
	endproperty
	a_stayDown: assert property (p_stayDown) else $error("left early");
	property p_wake;
		s_wakeOk |-> ##[1:2] !inShutdown;
	endproperty
	a_wake: assert property (p_wake) else $error("wake ignored");
	property p_warn;
		cellConvDone && dieAboveWarn && !digitalReset && !inShutdown
			|=> thermalWarningFlag;
	endproperty
	a_warn: assert property (p_warn) else $error("no warning");
	property p_soft;
		softReset |=> digitalReset;
	endproperty
	a_soft: assert property (p_soft) else $error("no soft reset");
	property p_supply;
		!supplyValid |=> digitalReset;
	endproperty
	a_supply: assert property (p_supply) else $error("supply reset");
	property p_rstKeep;
		resetOccurredFlag && !clearResetOccurred |=> resetOccurredFlag;
	endproperty
	a_rstKeep: assert property (p_rstKeep) else $error("reset flag lost");
	property p_noBist;
		tempStat.singleMode |-> !tempStat.bistActive;
	endproperty
	a_noBist: assert property (p_noBist) else $error("test in single");
	// setup may only move when the group is switched on again
	property p_latch;
		voltStat.running && $past(voltStat.running)
			|-> $stable(voltStat.singleMode);
	endproperty
	a_latch: assert property (p_latch) else $error("setup moved");
endmodule
bind protector_supervisor supervisor_checker u_chk (.clock, .rstn,
	.dieOverTemp, .dieBelowRelease, .wakeCommand, .cellConvDone,
	.dieAboveWarn, .softReset, .supplyValid, .clearThermalShutdown,
	.clearResetOccurred, .tempStat, .voltStat, .inShutdown,
	.discardTraffic, .digitalReset, .thermalShutdownFlag,
	.thermalWarningFlag, .resetOccurredFlag, .faultOutputLow);

// ===== protector_supervisor_tb.sv
`timescale 1ns/1ps
module protector_supervisor_tb;
	import supervisor_pkg::*;
	localparam int WH = 20;
	logic clock = 1'h0;
	logic rstn = 1'h0;
	logic isStackDevice = 1'h0;
	logic tempComparatorsOn = 1'h0, voltComparatorsOn = 1'h0;
	group_cfg_t tempCfg = '0, voltCfg = '0;
	logic [5:0] tempTrip = 6'h0, voltTrip = 6'h0;
	logic dieOverTemp = 1'h0, dieBelowRelease = 1'h1;
	logic cellConvDone = 1'h0, dieAboveWarn = 1'h0;
	logic fastOscillator = 1'h0, slowOscillator = 1'h0;
	logic supplyValid = 1'h1, softReset = 1'h0, wakeTone = 1'h0;
	logic referenceValid = 1'h1, bandgapValid = 1'h1;
	logic wakePinLow = 1'h0, wakeCommand = 1'h0;
	logic clearThermalShutdown = 1'h0, clearThermalWarning = 1'h0;
	logic clearOscillatorFault = 1'h0, clearResetOccurred = 1'h0;
	logic [3:0] faultMask = 4'h0;
	logic fastStop = 1'h0; // freezes the fast oscillator
	int slowHalf = 60, slowCnt = 0, cycles = 0; // slow half period
	int fail_count = 0, checked = 0;
	group_stat_t tempStat, voltStat;
	logic [5:0] tempFaults, voltFaults;
	logic inShutdown, discardTraffic, digitalReset, thermalShutdownFlag;
	logic thermalWarningFlag, oscillatorFaultFlag, resetOccurredFlag;
	logic faultOutputLow;
	protector_supervisor #(.WAKE_HOLD(WH), .SLOW_WD(200)) DUT (.clock,
		.rstn, .isStackDevice, .tempComparatorsOn, .voltComparatorsOn,
		.tempCfg, .voltCfg, .tempTrip, .voltTrip, .dieOverTemp,
		.dieBelowRelease, .cellConvDone, .dieAboveWarn, .fastOscillator,
		.slowOscillator, .supplyValid, .referenceValid,
		.bandgapValid, .softReset, .wakeTone, .wakePinLow,
		.wakeCommand, .clearThermalShutdown, .clearThermalWarning,
		.clearOscillatorFault, .clearResetOccurred, .faultMask, .tempStat,
		.voltStat, .tempFaults, .voltFaults, .inShutdown, .discardTraffic,
		.digitalReset, .thermalShutdownFlag, .thermalWarningFlag,
		.oscillatorFaultFlag, .resetOccurredFlag, .faultOutputLow);
	initial forever #4 clock = ~clock;
	// oscillators; a huge half period means a dead slow oscillator
	always @(posedge clock) begin
		if (!fastStop) fastOscillator <= ~fastOscillator;
		slowCnt <= slowCnt + 1;
		if (slowCnt >= slowHalf - 1) begin
			slowCnt <= 0;
			slowOscillator <= ~slowOscillator;
		end
	end
	// hang guard, well above the expected run length
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			give_verdict();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic chk(input string what, input logic [8:0] exp,
		input logic [8:0] got);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic logic pick(input int sel);
		case (sel)
			0: return digitalReset;
			1: return oscillatorFaultFlag;
			default: return tempStat.bistActive;
		endcase
	endfunction
	// bounded wait; the first look lets the edge's updates land
	task automatic wait_hi(input string what, input int sel, input int lim);
		int n;
		n = 0;
		#1;
		while (pick(sel) !== 1'h1 && n < lim) begin
			@(posedge clock);
			#1;
			n++;
		end
		chk(what, 9'h1, {8'h0, pick(sel)});
	endtask
	// off for one edge, then on, so the new setup is taken
	task automatic arm(input bit g, input logic [1:0] m,
		input logic [5:0] en, input logic meas);
		tick(1);
		if (g) begin
			voltComparatorsOn <= 1'h0;
			voltCfg <= {m, en, meas};
		end else begin
			tempComparatorsOn <= 1'h0;
			tempCfg <= {m, en, meas};
		end
		tick(1);
		if (g) voltComparatorsOn <= 1'h1;
		else tempComparatorsOn <= 1'h1;
		tick(2);
	endtask
	task automatic give_verdict();
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		tick(16);
		rstn <= 1'h1;
		tick(2);
		#1;
		chk("after reset", 9'h3, {inShutdown, thermalShutdownFlag,
			resetOccurredFlag, faultOutputLow});
		$display("test reset done");
		tick(1);
		dieOverTemp <= 1'h1;
		dieBelowRelease <= 1'h0;
		tick(1);
		dieOverTemp <= 1'h0;
		#1;
		chk("shutdown", 9'hF, {inShutdown, thermalShutdownFlag,
			discardTraffic, faultOutputLow});
		tick(1);
		wakeCommand <= 1'h1;
		tick(1);
		wakeCommand <= 1'h0;
		tick(3);
		#1;
		chk("hot wake", 9'h1, inShutdown);
		tick(1);
		dieBelowRelease <= 1'h1;
		wakeCommand <= 1'h1;
		tick(1);
		wakeCommand <= 1'h0;
		tick(3);
		#1;
		chk("woken", 9'h2, {inShutdown, thermalShutdownFlag,
			faultOutputLow});
		tick(1);
		clearThermalShutdown <= 1'h1;
		clearResetOccurred <= 1'h1;
		tick(1);
		clearThermalShutdown <= 1'h0;
		clearResetOccurred <= 1'h0;
		$display("test thermal done");
		// lowest enabled channel is bit 2 of 010100
		for (int i = 2; i < 4; i++) begin
			arm(0, i[1:0], 6'h14, 1'h0);
			tempTrip <= 6'h14;
			tick(2);
			#1;
			chk("single", 9'h4, {5'h0, tempStat.channel,
				tempStat.bistActive});
			chk("captured", 9'h4, tempFaults);
			tick(1);
			tempTrip <= 6'h0;
		end
		tempCfg <= {MODE_BIST_RR, 6'h01, 1'h0};
		tick(3);
		#1;
		chk("not relatched", 9'h12, {tempStat.singleMode,
			tempStat.bistActive, tempStat.channel});
		for (int g = 0; g < 2; g++) begin
			arm(g[0], MODE_SINGLE_A, 6'h08, 1'h1);
			tempTrip <= 6'h3F;
			voltTrip <= 6'h3F;
			tick(2);
			#1;
			chk("masked", 9'h40, g ? {voltStat.outputsMasked, voltFaults}
				: {tempStat.outputsMasked, tempFaults});
		end
		tempTrip <= 6'h0;
		voltTrip <= 6'h0;
		arm(1, MODE_BIST_RR, 6'h3F, 1'h0);
		arm(0, MODE_BIST_RR, 6'h3F, 1'h0);
		wait_hi("self test", 2, 2500);
		$display("test comparators done");
		tick(1);
		cellConvDone <= 1'h1;
		dieAboveWarn <= 1'h1;
		tick(1);
		cellConvDone <= 1'h0;
		tick(1);
		#1;
		chk("warning", 9'h2, {thermalWarningFlag, faultOutputLow});
		tick(1);
		clearThermalWarning <= 1'h1;
		dieAboveWarn <= 1'h0;
		tick(1);
		clearThermalWarning <= 1'h0;
		slowHalf <= 2;
		wait_hi("slow freq", 1, 400);
		tick(1);
		slowHalf <= 60;
		// let the last short half period land before clearing
		tick(1);
		clearOscillatorFault <= 1'h1;
		tick(1);
		clearOscillatorFault <= 1'h0;
		#1;
		chk("osc cleared", 9'h0, oscillatorFaultFlag);
		$display("test warning done");
		// soft, tone, wake pin, fast dead, slow dead, supply, ref, bandgap
		for (int k = 0; k < 8; k++) begin
			tick(1);
			clearResetOccurred <= 1'h0;
			isStackDevice <= (k == 1);
			case (k)
				0: softReset <= 1'h1;
				1: wakeTone <= 1'h1;
				2: wakePinLow <= 1'h1;
				3: fastStop <= 1'h1;
				4: slowHalf <= 100000;
				5: supplyValid <= 1'h0;
				6: referenceValid <= 1'h0;
				default: bandgapValid <= 1'h0;
			endcase
			tick(k == 2 ? WH + 2 : 1);
			softReset <= 1'h0;
			wakeTone <= 1'h0;
			wakePinLow <= 1'h0;
			wait_hi("digital reset", 0, 400);
			tick(5);
			#1;
			if (k >= 5)
				chk("held", 9'h1, digitalReset);
			fastStop <= 1'h0;
			slowHalf <= 60;
			supplyValid <= 1'h1;
			referenceValid <= 1'h1;
			bandgapValid <= 1'h1;
			// after a watchdog reset: long wake pin low, then release, for another digital reset
			if (k == 3 || k == 4) begin
				wakePinLow <= 1'h1;
				tick(WH + 2);
				wakePinLow <= 1'h0;
			end
			tick(300);
			#1;
			chk("after dreset", 9'h2, {resetOccurredFlag,
				tempStat.running});
			clearResetOccurred <= 1'h1;
		end
		$display("test digital reset done");
		give_verdict();
	end
endmodule

// ===== supervisor_pkg.sv
package supervisor_pkg;
	// comparator group mode codes
	localparam logic [1:0] MODE_BIST_RR = 2'h0;
	localparam logic [1:0] MODE_PLAIN_RR = 2'h1;
	localparam logic [1:0] MODE_SINGLE_A = 2'h2;
	localparam logic [1:0] MODE_SINGLE_B = 2'h3;
	localparam int NUM_CHANNELS = 6;
	// clock rate and documented times
	localparam int CLOCK_HZ = 125000000;
	localparam int SLOT_NS = 1000;
	localparam int SLOT_CYCLES = (SLOT_NS * (CLOCK_HZ / 1000000)) / 1000;
	localparam int WAKE_HOLD_US = 2000;
	localparam int WAKE_HOLD_CYCLES = WAKE_HOLD_US * (CLOCK_HZ / 1000000);
	localparam int FAST_WD_NS = 1000;
	localparam int FAST_WD_CYCLES = (FAST_WD_NS * (CLOCK_HZ / 1000000)) / 1000;
	localparam int SLOW_WD_US = 100;
	localparam int SLOW_WD_CYCLES = SLOW_WD_US * (CLOCK_HZ / 1000000);
	// slow oscillator period window, in clock cycles per half period
	localparam int SLOW_HALF_MIN = 40;
	localparam int SLOW_HALF_MAX = 80;
	localparam int CNT_W = 20;

	// latched configuration of one comparator group
	typedef struct packed {
		logic [1:0] mode;
		logic [NUM_CHANNELS-1:0] chanEnables;
		logic thresholdMeas;
	} group_cfg_t;

	// status seen by one comparator group
	typedef struct packed {
		logic running;
		logic singleMode;
		logic bistActive;
		logic outputsMasked;
		logic [2:0] channel;
	} group_stat_t;
endpackage
